// ==== verilog/pss_top.sv ====
// Purpose : conventional pci side of the bridge: speed, parity, errors, reset, target, arbitration
// Assumes : pci pins live on pciClk; straps, pme and the core port on clk
// Notes   : clkEn freezes the core domain only; the pci side follows the bus
// How it works
// - the interface selects 33 MHz when the speed pin is 0 and 66 MHz when it is 1.
// - the speed pin counts only in master clocking and is ignored under slave clocking.
// - parity is even over the 32 address/data lines and the four command/enable lines.
// - the master drives parity for address and write data, the target for read data.
// - the agent that received data with bad parity asserts the parity error line for it.
// - bad parity in an address phase is reported on the open drain system error line.
// - the power management line is an input whose assertion is reported as an event.
// - with the internal arbiter all four request lines are inputs from masters.
// - with an external arbiter request line 0 is our output and lines 3 to 1 stay inputs.
// - arbiter mode is taken from the power-up arbiter select pin level.
// - the bridge drives the bus reset that resets every device on the bus.
// - a target asserts stop to end the transaction at the current data phase.
// - the target asserts ready only when it can complete; no phase completes without it.
// - with the internal arbiter all four grant lines are outputs.
// - with an external arbiter grant line 0 is an input and lines 3 to 1 stay outputs.
`include "pss_regs.svh"
module pss_top (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        clkEn,
  input  wire logic        pciClk,
  input  wire logic        m66En,
  input  wire logic        clockMasterStrap,
  input  wire logic        powerup_arbiter_select_pin,
  input  wire logic        pmeN,
  output logic             pciRstN,
  output logic             clkSel66,
  output logic             arbInternal,
  output logic             pmeEvent,
  output logic             parityErr,
  output logic             sysErr,
  input  wire logic        ownBusReq,
  output logic             ownBusGrant,
  output logic             phaseValid,
  output logic             phaseWrite,
  output logic [31:0]      phaseAddr,
  output logic [31:0]      phaseWrData,
  output logic [3:0]       phaseBe,
  input  wire logic        phaseAck,
  input  wire logic [31:0] phaseRdData,
  input  wire logic        phaseStop,
  input  wire logic        frameN,
  input  wire logic        irdyN,
  input  wire logic [3:0]  cbeIn,
  input  wire logic [31:0] adIn,
  output logic      [31:0] adOut,
  output logic             adOe,
  input  wire logic        parIn,
  output logic             parOut,
  output logic             parOe,
  input  wire logic        perrNIn,
  output logic             perrNOut,
  output logic             perrNOe,
  input  wire logic        serrNIn,
  output logic             serrNOut,
  output logic             serrNOe,
  input  wire logic        devselNIn,
  output logic             devselNOut,
  output logic             devselNOe,
  input  wire logic        trdyNIn,
  output logic             trdyNOut,
  output logic             trdyNOe,
  input  wire logic        stopNIn,
  output logic             stopNOut,
  output logic             stopNOe,
  input  wire logic [3:0]  reqNIn,
  output logic      [3:0]  reqNOut,
  output logic      [3:0]  reqNOe,
  input  wire logic [3:0]  gntNIn,
  output logic      [3:0]  gntNOut,
  output logic      [3:0]  gntNOe
);
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [`PSS_RST_CNT_W-1:0] rstCnt_r;
  logic                      pciRstN_r;
  logic                      strapDone_r;
  logic                      clkSel66_r;
  logic                      pmePrev_r;
  logic [2:0]                tglPrev_r;
  logic                      pmeEvent_r;
  logic                      parityErr_r;
  logic                      sysErr_r;
  logic                      phaseValid_r;
  logic                      phaseWrite_r;
  logic [31:0]               phaseAddr_r;
  logic [31:0]               phaseWrData_r;
  logic [3:0]                phaseBe_r;
  logic                      pending_r;
  logic                      ackTgl_r;
  logic [31:0]               ackRdData_r;
  logic                      ackStop_r;
  logic [7:0]                coreQ;
  logic [2:0]                linkQ;
  logic                      linkRst;
  logic                      arbInt_r;
  logic                      linkStrap_r;
  pss_pkg::pss_tgt_t         st_r;
  logic                      frameNPrev_r;
  logic [31:0]               addr_r;
  logic                      write_r;
  logic [31:0]               wrData_r;
  logic [3:0]                be_r;
  logic                      reqTgl_r;
  logic                      ackPrev_r;
  logic                      trdyN_r;
  logic                      stopN_r;
  logic                      devselN_r;
  logic                      ctlOe_r;
  logic [31:0]               adOut_r;
  logic                      adOe_r;
  logic                      parOut_r;
  logic                      parOe_r;
  logic                      expPar_r;
  logic                      chkAddr_r;
  logic                      chkData_r;
  logic                      perrN_r;
  logic                      perrOe_r;
  logic                      serrOe_r;
  logic                      perrTgl_r;
  logic                      serrTgl_r;
  logic [3:0]                arbGntN;

  // ---------------------------------------------------------------
  // crossings: pins and link toggles into clk, core toggles into pciClk
  // ---------------------------------------------------------------
  pss_sync #(.W(8)) uCoreSync (
    .clk (clk),
    .rst (sys_rst),
    .d   ({~pmeN, m66En, clockMasterStrap, reqTgl_r, perrTgl_r, serrTgl_r,
           ~gntNIn[0], arbInt_r}),
    .q   (coreQ)
  );

  // link reset follows the bus reset, so the pci side idles while the bus is held
  pss_sync #(.W(1)) uRstSync (
    .clk (pciClk),
    .rst (1'b0),
    .d   (~pciRstN_r),
    .q   (linkRst)
  );

  // left out of reset so pin levels have settled when the link wakes up
  pss_sync #(.W(3)) uLinkSync (
    .clk (pciClk),
    .rst (1'b0),
    .d   ({powerup_arbiter_select_pin, ownBusReq, ackTgl_r}),
    .q   (linkQ)
  );

  // ---------------------------------------------------------------
  // core domain
  // ---------------------------------------------------------------
  wire       pmeSync = coreQ[7];
  wire       m66Sync = coreQ[6];
  wire       mstSync = coreQ[5];
  wire [2:0] tglSync = coreQ[4:2];
  // toggles mean nothing while the link is held, so a reset there makes no false pulse
  wire [2:0] tglEdge = (tglSync ^ tglPrev_r) & {3{pciRstN_r}};
  wire       holdDone = (rstCnt_r == `PSS_RST_CNT_W'(`PSS_RST_HOLD_CYC));

  // bus reset held for a fixed time after the core reset lets go
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rstCnt_r  <= '0;
      pciRstN_r <= 1'b0;
    end else if (clkEn) begin
      if (!holdDone) rstCnt_r <= rstCnt_r + 1'b1;
      pciRstN_r <= holdDone;
    end
  end

  // speed strap caught as the bus reset lets go, long after the synchroniser settled
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      strapDone_r <= 1'b0;
      clkSel66_r  <= 1'b0;
    end else if (clkEn && !strapDone_r && holdDone) begin
      strapDone_r <= 1'b1;
      clkSel66_r  <= mstSync & m66Sync;
    end
  end

  // event pulses from pme and the link toggles
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pmePrev_r   <= 1'b0;
      tglPrev_r   <= 3'h0;
      pmeEvent_r  <= 1'b0;
      parityErr_r <= 1'b0;
      sysErr_r    <= 1'b0;
    end else if (clkEn) begin
      pmePrev_r   <= pmeSync;
      tglPrev_r   <= tglSync;
      pmeEvent_r  <= pmeSync & ~pmePrev_r;
      parityErr_r <= tglEdge[1];
      sysErr_r    <= tglEdge[0];
    end
  end

  // data phase handshake: link request toggles in, core answer toggles back
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phaseValid_r  <= 1'b0;
      pending_r     <= 1'b0;
      ackTgl_r      <= 1'b0;
      ackStop_r     <= 1'b0;
      ackRdData_r   <= '0;
      phaseWrite_r  <= 1'b0;
      phaseAddr_r   <= '0;
      phaseWrData_r <= '0;
      phaseBe_r     <= 4'h0;
    end else if (clkEn) begin
      phaseValid_r <= tglEdge[2];
      if (tglEdge[2]) begin
        // link words stand still until our answer, so they are safe to take here
        pending_r     <= 1'b1;
        phaseWrite_r  <= write_r;
        phaseAddr_r   <= addr_r;
        phaseWrData_r <= wrData_r;
        phaseBe_r     <= be_r;
      end else if (phaseAck && pending_r) begin
        pending_r   <= 1'b0;
        ackTgl_r    <= ~ackTgl_r;
        ackRdData_r <= phaseRdData;
        ackStop_r   <= phaseStop;
      end
    end
  end

  assign pciRstN     = pciRstN_r;
  assign clkSel66    = clkSel66_r;
  assign arbInternal = coreQ[0];
  assign ownBusGrant = coreQ[1] & ~coreQ[0];
  assign pmeEvent    = pmeEvent_r;
  assign parityErr   = parityErr_r;
  assign sysErr      = sysErr_r;
  assign phaseValid  = phaseValid_r;
  assign phaseWrite  = phaseWrite_r;
  assign phaseAddr   = phaseAddr_r;
  assign phaseWrData = phaseWrData_r;
  assign phaseBe     = phaseBe_r;

  // ---------------------------------------------------------------
  // link domain: arbiter mode and request/grant direction
  // ---------------------------------------------------------------
  always_ff @(posedge pciClk) begin
    if (linkRst) begin
      linkStrap_r <= 1'b0;
      arbInt_r    <= 1'b0;
    end else if (!linkStrap_r) begin
      linkStrap_r <= 1'b1;
      arbInt_r    <= linkQ[2];
    end
  end

  wire busIdle = frameN & irdyN;

  pss_arbiter uArb (
    .clk     (pciClk),
    .rst     (linkRst),
    .en      (arbInt_r),
    .busIdle (busIdle),
    .reqN    (reqNIn),
    .gntN    (arbGntN)
  );

  assign reqNOe  = arbInt_r ? `PSS_REQ_OE_INT : `PSS_REQ_OE_EXT;
  assign reqNOut = {3'h7, ~linkQ[1]};
  assign gntNOe  = arbInt_r ? `PSS_GNT_OE_INT : `PSS_GNT_OE_EXT;
  assign gntNOut = arbInt_r ? arbGntN : `PSS_ALL_HIGH;

  // ---------------------------------------------------------------
  // link domain: target data phases
  // ---------------------------------------------------------------
  wire frameStart = frameNPrev_r & ~frameN;
  wire cmdRd      = (cbeIn == `PSS_CMD_MEM_RD);
  wire cmdWr      = (cbeIn == `PSS_CMD_MEM_WR);
  wire addrHit    = (adIn[`PSS_BASE_MSB:`PSS_BASE_LSB] == `PSS_BASE_HI) & (cmdRd | cmdWr);
  wire ackSeen    = linkQ[0] ^ ackPrev_r;
  wire launch     = write_r ? ~irdyN : 1'b1;
  wire phaseDone  = (st_r == pss_pkg::TGT_READY) & ~irdyN;
  wire lastPhase  = ~stopN_r | frameN;

  // claim, wait for the core, ready, and release with a turnaround
  always_ff @(posedge pciClk) begin
    if (linkRst) begin
      st_r      <= pss_pkg::TGT_IDLE;
      addr_r    <= '0;
      write_r   <= 1'b0;
      wrData_r  <= '0;
      be_r      <= 4'h0;
      reqTgl_r  <= 1'b0;
      trdyN_r   <= 1'b1;
      stopN_r   <= 1'b1;
      devselN_r <= 1'b1;
      ctlOe_r   <= 1'b0;
      adOut_r   <= '0;
      adOe_r    <= 1'b0;
    end else begin
      case (st_r)
        pss_pkg::TGT_IDLE: begin
          ctlOe_r <= frameStart & addrHit;
          if (frameStart && addrHit) begin
            st_r      <= pss_pkg::TGT_DATA;
            addr_r    <= adIn;
            write_r   <= cmdWr;
            devselN_r <= 1'b0;
            adOe_r    <= cmdRd;
          end
        end
        pss_pkg::TGT_DATA: begin
          if (frameN && irdyN) begin
            st_r <= pss_pkg::TGT_TURN;
          end else if (launch) begin
            reqTgl_r <= ~reqTgl_r;
            wrData_r <= adIn;
            be_r     <= cbeIn;
            st_r     <= pss_pkg::TGT_WAIT;
          end
        end
        pss_pkg::TGT_WAIT: begin
          if (ackSeen) begin
            trdyN_r <= 1'b0;
            stopN_r <= ~ackStop_r;
            adOut_r <= ackRdData_r;
            st_r    <= pss_pkg::TGT_READY;
          end
        end
        pss_pkg::TGT_READY: begin
          if (!irdyN) begin
            trdyN_r <= 1'b1;
            addr_r  <= addr_r + `PSS_ADDR_STEP;
            st_r    <= lastPhase ? pss_pkg::TGT_TURN : pss_pkg::TGT_DATA;
            if (lastPhase) adOe_r <= 1'b0;
          end
        end
        pss_pkg::TGT_TURN: begin
          // stop stands until the master lets frame go
          if (frameN) begin
            stopN_r   <= 1'b1;
            devselN_r <= 1'b1;
            adOe_r    <= 1'b0;
            st_r      <= pss_pkg::TGT_IDLE;
          end
        end
        default: st_r <= pss_pkg::TGT_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // link domain: parity generation, checking and error lines
  // ---------------------------------------------------------------
  wire dataRx      = phaseDone & write_r;
  wire parMismatch = parIn ^ expPar_r;

  always_ff @(posedge pciClk) begin
    if (linkRst) begin
      frameNPrev_r <= 1'b1;
      ackPrev_r    <= 1'b0;
      parOut_r     <= 1'b0;
      parOe_r      <= 1'b0;
      expPar_r     <= 1'b0;
      chkAddr_r    <= 1'b0;
      chkData_r    <= 1'b0;
      perrN_r      <= 1'b1;
      perrOe_r     <= 1'b0;
      serrOe_r     <= 1'b0;
      perrTgl_r    <= 1'b0;
      serrTgl_r    <= 1'b0;
    end else begin
      frameNPrev_r <= frameN;
      ackPrev_r    <= linkQ[0];
      parOut_r     <= pss_pkg::pssEvenPar(adOut_r, cbeIn);
      parOe_r      <= adOe_r;
      expPar_r     <= pss_pkg::pssEvenPar(adIn, cbeIn);
      chkAddr_r    <= frameStart;
      chkData_r    <= dataRx;
      perrN_r      <= ~(chkData_r & parMismatch);
      perrOe_r     <= (st_r != pss_pkg::TGT_IDLE) | chkData_r | ~perrN_r;
      serrOe_r     <= chkAddr_r & parMismatch;
      if (chkData_r && parMismatch) perrTgl_r <= ~perrTgl_r;
      if (chkAddr_r && parMismatch) serrTgl_r <= ~serrTgl_r;
    end
  end

  assign adOut      = adOut_r;
  assign adOe       = adOe_r;
  assign parOut     = parOut_r;
  assign parOe      = parOe_r;
  assign perrNOut   = perrN_r;
  assign perrNOe    = perrOe_r;
  assign serrNOut   = 1'b0;
  assign serrNOe    = serrOe_r;
  assign devselNOut = devselN_r;
  assign devselNOe  = ctlOe_r;
  assign trdyNOut   = trdyN_r;
  assign trdyNOe    = ctlOe_r;
  assign stopNOut   = stopN_r;
  assign stopNOe    = ctlOe_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence sPhaseDone;
    !trdyNOut && !irdyN;
  endsequence
  sequence sStopWhileFrame;
    !stopNOut && !frameN;
  endsequence

  AST_PAR_NEXT: assert property (@(posedge pciClk) disable iff (linkRst)
    adOe |=> (parOut == ((^$past(adOut)) ^ (^$past(cbeIn)))))
    else $error("read parity wrong or late");
  AST_PAR_READ_ONLY: assert property (@(posedge pciClk) disable iff (linkRst)
    parOe |-> $past(adOe) && !write_r)
    else $error("parity driven outside a read");
  AST_PERR_RAISE: assert property (@(posedge pciClk) disable iff (linkRst)
    sPhaseDone ##0 write_r ##1 parMismatch |=> !perrNOut && perrNOe)
    else $error("data parity error not reported");
  AST_SERR_PULSE: assert property (@(posedge pciClk) disable iff (linkRst)
    (chkAddr_r && parMismatch) |=> serrNOe && !serrNOut ##1 !serrNOe)
    else $error("address parity error not one serr pulse");
  AST_REQ_DIR: assert property (@(posedge pciClk) disable iff (linkRst)
    !arbInt_r |-> reqNOe == 4'h1 && gntNOe == 4'hE)
    else $error("external arbiter pin direction wrong");
  AST_GNT_INT: assert property (@(posedge pciClk) disable iff (linkRst)
    arbInt_r |-> gntNOe == 4'hF && reqNOe == 4'h0 && $onehot0(~gntNOut))
    else $error("internal arbiter pin direction wrong");
  AST_TRDY_CAUSE: assert property (@(posedge pciClk) disable iff (linkRst)
    $fell(trdyNOut) |-> $past(ackSeen) && $past(st_r) == pss_pkg::TGT_WAIT)
    else $error("ready without a core answer");
  AST_STOP_HOLD: assert property (@(posedge pciClk) disable iff (linkRst)
    sStopWhileFrame ##1 !frameN |-> !stopNOut)
    else $error("stop released while frame still low");
  AST_BUS_RST: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(sys_rst) |-> !pciRstN [*8])
    else $error("bus reset released too early");
  AST_PME: assert property (@(posedge clk) disable iff (sys_rst)
    (clkEn && pmeSync && !pmePrev_r) |=> pmeEvent)
    else $error("pme event lost");
  AST_SPEED: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(strapDone_r) && !$past(mstSync) |-> !clkSel66)
    else $error("speed set without master clocking");
endmodule

// ==== verilog/pss_regs.svh ====
// Purpose : named constants of the pci side signalling block
// Assumes : included by bare name from the design files
// Notes   : times in ns, cycle counts derived from the core clock period
`ifndef PSS_REGS_SVH
`define PSS_REGS_SVH
`define PSS_CLK_PERIOD_NS 4
`define PSS_RST_HOLD_NS   1000
`define PSS_RST_HOLD_CYC  ((`PSS_RST_HOLD_NS + `PSS_CLK_PERIOD_NS - 1) / `PSS_CLK_PERIOD_NS)
`define PSS_RST_CNT_W     8
`define PSS_CMD_MEM_RD    4'h6
`define PSS_CMD_MEM_WR    4'h7
`define PSS_BASE_HI       8'h40
`define PSS_BASE_MSB      31
`define PSS_BASE_LSB      24
`define PSS_ADDR_STEP     32'h0000_0004
`define PSS_REQ_OE_INT    4'h0
`define PSS_REQ_OE_EXT    4'h1
`define PSS_GNT_OE_INT    4'hF
`define PSS_GNT_OE_EXT    4'hE
`define PSS_ALL_HIGH      4'hF
`endif

// ==== verilog/pss_pkg.sv ====
// Purpose : types and shared decode of the pci side signalling block
// Assumes : used as pss_pkg::name, never imported
// Notes   : parity helper serves both generation and checking
package pss_pkg;
  typedef enum logic [2:0] {
    TGT_IDLE,
    TGT_DATA,
    TGT_WAIT,
    TGT_READY,
    TGT_TURN
  } pss_tgt_t;

  // even parity: ones over ad and cbe plus the result come out even
  function automatic logic pssEvenPar(input logic [31:0] ad, input logic [3:0] cbe);
    pssEvenPar = (^ad) ^ (^cbe);
  endfunction
endpackage

// ==== verilog/pss_sync.sv ====
// Purpose : two flip-flop level synchroniser
// Assumes : bits are independent levels or toggles
// Notes   : first stage feeds only the second stage
module pss_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // ---------------------------------------------------------------
  // two stages
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '0;
      q_r    <= '0;
    end else begin
      meta_r <= d;
      q_r    <= meta_r;
    end
  end

  assign q = q_r;
endmodule

// ==== verilog/pss_arbiter.sv ====
// Purpose : round robin arbiter for four bus masters
// Assumes : runs on the pci clock, requests active low
// Notes   : grant moves only while the bus is idle, so a running master keeps it
module pss_arbiter (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       en,
  input  wire logic       busIdle,
  input  wire logic [3:0] reqN,
  output logic      [3:0] gntN
);
  logic [1:0] last_r;
  logic [3:0] gnt_r;
  logic [3:0] gnt_nxt;
  logic [1:0] win_nxt;
  logic       hit;

  // search starts after the last winner to keep it fair
  always_comb begin
    logic [1:0] idx;
    idx     = 2'h0;
    gnt_nxt = 4'h0;
    win_nxt = last_r;
    hit     = 1'b0;
    for (int i = 1; i <= 4; i++) begin
      idx = last_r + i[1:0];
      if (!hit && !reqN[idx]) begin
        hit     = 1'b1;
        win_nxt = idx;
        gnt_nxt = 4'h1 << idx;
      end
    end
  end

  // grant register
  always_ff @(posedge clk) begin
    if (rst || !en) begin
      gnt_r  <= 4'h0;
      last_r <= 2'h0;
    end else if (busIdle) begin
      gnt_r <= gnt_nxt;
      if (hit) begin
        last_r <= win_nxt;
      end
    end
  end

  assign gntN = ~gnt_r;
endmodule

// ==== test/pss_pci_master.sv ====
// Purpose : pci initiator model issuing single-word memory reads and writes
// Assumes : target pins are resolved by the bench
// Notes   : ad lines released after a write show the inverse of the data; after a read they keep the address
`include "pss_regs.svh"
module pss_pci_master (
  input  wire logic        pciClk,
  input  wire logic        trdyN,
  input  wire logic        stopN,
  input  wire logic [31:0] adBus,
  input  wire logic        parBus,
  output logic             frameN = 1'b1,
  output logic             irdyN = 1'b1,
  output logic [3:0]       cbe = 4'hF,
  output logic [31:0]      ad = 32'h0000_0000,
  output logic             par = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // one write phase; parity trails what it covers by one clock
  task automatic write(input logic [31:0] a, d, input logic bA, bD, output logic st, ok);
    int n = 0;
    @(negedge pciClk);
    {frameN, ad, cbe} = {1'b0, a, `PSS_CMD_MEM_WR};
    @(negedge pciClk);
    par = (^ad) ^ (^cbe) ^ bA;
    {frameN, irdyN, ad, cbe} = {2'b10, d, 4'h0};
    do @(posedge pciClk); while (trdyN !== 1'b0 && ++n < 40);
    {st, ok} = {~stopN, n < 40};
    @(negedge pciClk);
    par = (^ad) ^ (^cbe) ^ bD;
    {irdyN, ad, cbe} = {1'b1, ~ad, 4'hF};
    @(negedge pciClk);
    par = ~par;
  endtask
  // one read phase; the target answers on ad, then a clock later on par
  task automatic read(input logic [31:0] a, output logic [31:0] d, output logic p, ok);
    int n = 0;
    @(negedge pciClk);
    {frameN, ad, cbe} = {1'b0, a, `PSS_CMD_MEM_RD};
    @(negedge pciClk);
    par = (^ad) ^ (^cbe);
    {frameN, irdyN, cbe} = {2'b10, 4'h0};
    do @(posedge pciClk); while (trdyN !== 1'b0 && ++n < 40);
    {d, ok} = {adBus, n < 40};
    @(negedge pciClk);
    {irdyN, cbe} = {1'b1, 4'hF};
    @(posedge pciClk);
    p = parBus;
  endtask
endmodule

// ==== test/tb_top.sv ====
// Purpose : self-checking bench for the pci side signalling block
// Assumes : the core side accepts every phase at once
// Notes   : released pci lines read high, as pulled up
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, pciClk = 0, sys_rst = 1, clkEn = 1, pmeN = 1, ownBusReq = 0, phaseAck = 0;
  logic phaseStop = 0, m66En, clockMasterStrap, powerup_arbiter_select_pin, frameN, irdyN;
  logic pciRstN, clkSel66, arbInternal, pmeEvent, parityErr, sysErr, ownBusGrant, phaseValid;
  logic phaseWrite, adOe, parOut, parOe, perrNOut, perrNOe, serrNOut, serrNOe, parM, st;
  logic devselNOut, devselNOe, trdyNOut, trdyNOe, stopNOut, stopNOe;
  logic [31:0] phaseAddr, phaseWrData, adOut, adM, gotData, gotAddr;
  logic [31:0] phaseRdData = 32'hC3C3_5A5A;
  logic [4:0] gotCtl;
  logic [3:0] phaseBe, reqNOut, reqNOe, gntNOut, gntNOe, cbeIn, reqM = 4'hF, gntM = 4'hF;
  int errors = 0, n_checks = 0, nPe = 0, nSe = 0, nPm = 0, nPl = 0, nDs = 0, n;
  // wire levels from every driver; serr is open drain
  wire trdyNIn = trdyNOut | ~trdyNOe;
  wire stopNIn = stopNOut | ~stopNOe;
  wire perrNIn = perrNOut | ~perrNOe;
  wire devselNIn = devselNOut | ~devselNOe;
  wire serrNIn = ~serrNOe;
  wire parIn = parOe ? parOut : parM;
  wire [31:0] adIn = adOe ? adOut : adM;
  wire [3:0] reqNIn = (reqNOe & reqNOut) | (~reqNOe & reqM);
  wire [3:0] gntNIn = (gntNOe & gntNOut) | (~gntNOe & gntM);
  pss_top u_pss_top (.*);
  pss_pci_master u_pss_pci_master (.pciClk, .trdyN(trdyNIn), .stopN(stopNIn), .frameN,
    .adBus(adIn), .parBus(parIn),
    .irdyN, .cbe(cbeIn), .ad(adM), .par(parM));
  initial forever #2 clk = ~clk;
  initial #7 forever #24 pciClk = ~pciClk;
  // pulses are counted so a scenario can look after the crossing
  always @(posedge clk) begin
    nPe += (parityErr === 1'b1);
    nSe += (sysErr === 1'b1);
    nPm += (pmeEvent === 1'b1);
  end
  always @(posedge pciClk) begin
    nPl += (perrNIn === 1'b0);
    nDs += (devselNIn === 1'b0);
  end
  // the core takes each offered phase on the next edge
  always @(negedge clk) begin
    phaseAck <= (phaseValid === 1'b1);
    if (phaseValid === 1'b1) {gotData, gotAddr, gotCtl} <= {phaseWrData, phaseAddr, phaseWrite, phaseBe};
  end
  task automatic chk(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // straps are read once, after the bus reset hold
  task automatic doReset(input logic ms, m6, ar);
    {sys_rst, clockMasterStrap, m66En, powerup_arbiter_select_pin} = {1'b1, ms, m6, ar};
    repeat (8) @(negedge clk);
    chk(pciRstN, 0);
    sys_rst = 1'b0;
    for (n = 0; pciRstN !== 1'b1 && n < 400; n++) @(negedge clk);
    chk(n > 240 && n < 260, 1);
    if (n == 400) test_done();
    repeat (12) @(posedge pciClk);
    @(negedge clk);
  endtask
  task automatic xfer(input logic [31:0] a, d, input logic bA, bD);
    logic ok;
    u_pss_pci_master.write(a, d, bA, bD, st, ok);
    chk(ok, 1);
    if (!ok) test_done();
    repeat (6) @(posedge pciClk);
    @(negedge clk);
  endtask
  // internal arbiter: a lone request is granted; pme gives one event
  task automatic scnInternal;
    chk(clkSel66, 1);
    chk(arbInternal, 1);
    chk({reqNOe, gntNOe}, 8'h0F);
    reqM = 4'hB;
    for (n = 0; gntNIn !== 4'hB && n < 99; n++) @(negedge clk);
    chk(gntNIn, 4'hB);
    {reqM, pmeN} = {4'hF, 1'b0};
    repeat (5) @(negedge clk);
    pmeN = 1'b1;
    repeat (5) @(negedge clk);
    chk(nPm, 1);
  endtask
  // read: the target claims, answers with core data and drives parity after it
  task automatic scnRead;
    logic [31:0] d;
    logic p, ok;
    u_pss_pci_master.read(32'h4000_0100, d, p, ok);
    chk(ok, 1);
    if (!ok) test_done();
    chk(d, phaseRdData);
    chk(p, ^phaseRdData);
    chk(nDs > 1, 1);
    repeat (6) @(posedge pciClk);
    @(negedge clk);
    chk(gotAddr, 32'h4000_0100);
    chk(gotCtl, 5'h00);
  endtask
  // stop with data, then bad data parity, then bad address parity
  task automatic scnParity;
    phaseStop = 1'b1;
    xfer(32'h4000_0010, 32'hA5A5_0F0F, 0, 0);
    phaseStop = 1'b0;
    chk(st, 1);
    chk(gotData, 32'hA5A5_0F0F);
    chk(gotAddr, 32'h4000_0010);
    chk(gotCtl, 5'h10);
    chk(nPe + nSe + nPl, 0);
    xfer(32'h40FF_FFFC, 32'h1234_5678, 0, 1);
    chk(nPe * 16 + nPl, 17);
    xfer(32'h4000_0020, 32'h0000_0001, 1, 0);
    chk(nSe, 1);
  endtask
  // slave clocking ignores the speed pin; line 0 turns round
  task automatic scnExternal;
    doReset(0, 1, 0);
    chk(clkSel66, 0);
    chk(arbInternal, 0);
    chk({reqNOe, gntNOe}, 8'h1E);
    {ownBusReq, gntM} = {1'b1, 4'hE};
    repeat (6) @(posedge pciClk);
    @(negedge clk);
    chk(reqNIn, 4'hE);
    chk(ownBusGrant, 1);
  endtask
  initial begin
    doReset(1, 1, 1);
    scnInternal();
    scnRead();
    scnParity();
    scnExternal();
    test_done();
  end
endmodule
